// file: sync_master_model.sv
// Purpose: External synchronous master that makes the shift clock
// Assumes: Clock idles low, 125 ns period, 8 bits a word, LSB first
// Notes: Between frames the data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module sync_master_model (
    output logic ck_o,
    output logic dt_o,
    input wire logic dt_i
);
    ////////////////////////////////////////////////////////////////////////
    // Clock stands still outside frames
    initial begin
        ck_o = 1'h0;
        dt_o = 1'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    // One word each way; stretch slows the clock like a lazy master
    task automatic frame(input logic [7:0] tx, input int stretch,
                         output logic [7:0] rx);
        for (int i = 0; i < 8; i++) begin
            dt_o = tx[i]; // LSB first, set while clock low
            #(62 + stretch);
            ck_o = 1'h1; // Only this clock moves the shifters
            rx[i] = dt_i; // Device bit taken at the rise
            #(63 + stretch);
            ck_o = 1'h0;
        end
        #63;
        dt_o = ~dt_o; // Released: never leave a stale level
    endtask
endmodule
`default_nettype wire

// file: sync_serial_map.svh
// Purpose: Offsets, field positions, reset values and counts of the port
// Assumes: Word-aligned 32-bit register bus, data in bits 7:0
// Notes: Definitions only
`ifndef SYNC_SERIAL_MAP_SVH
`define SYNC_SERIAL_MAP_SVH
// Register byte offsets
`define SS_OFF_TX_CTRL 6'h00
`define SS_OFF_RX_CTRL 6'h04
`define SS_OFF_RX_DATA 6'h08
`define SS_OFF_TX_BUF 6'h0C
`define SS_OFF_FLAGS 6'h10
`define SS_OFF_EV_STAT 6'h14
`define SS_OFF_EV_MASK 6'h18
`define SS_OFF_INT_CTRL 6'h1C
`define SS_OFF_IRQ_EN 6'h20
`define SS_OFF_ALT_PIN 6'h24
// Field positions
`define SS_CLK_SRC 7
`define SS_TX_EN 5
`define SS_SYNC 4
`define SS_TX_IDLE 1
`define SS_PORT_EN 7
`define SS_SINGLE_RX 5
`define SS_CONT_RX 4
`define SS_OVERRUN 1
`define SS_RX_FLAG 5
`define SS_TX_FLAG 4
`define SS_GLOBAL_EN 7
`define SS_PERIPH_EN 6
`define SS_CK_ALT 2
`define SS_DT_ALT 1
// Event status bits
`define SS_EV_RX 0
`define SS_EV_TX 1
`define SS_EV_OVR 2
// Reset values and counts
`define SS_RST_BYTE 8'h00
`define SS_RST_EV 3'h0
`define SS_LAST_BIT 3'h7
`define SS_ISR_VECTOR 12'h004
`endif

// file: sync_serial_pkg.sv
// Purpose: Types shared by the serial port
// Assumes: Nothing
// Notes: Constants live in the map header
package sync_serial_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {mode_off, mode_receive,
        mode_transmit} port_mode_t;
endpackage

// file: sync_slave_serial.sv
// Purpose: Synchronous slave serial port that keeps shifting in sleep
// Assumes: Master drives the shift clock; bits go LSB first, 8 per word
// Notes: Master and asynchronous modes are not built here
// Function
// - Only slave synchronous mode shifts during sleep; others stop.
// - Shift registers advance only on the master's clock pin edges.
// - Reading receive data pops it; flag clears when buffer empties.
// - In sleep a full received word sets the receive flag and, if its enable is set, wakes.
// - Wake resumes next instruction, or calls vector 004h if enabled.
// - Writing the transmit buffer clears the buffer-empty flag.
// - Word clocked out: buffered byte moves in, flag set, core wakes if both enables are set.
// - After the move the buffer takes another byte, clearing the flag.
// - Transmit wake needs both transmit and peripheral enables.
// - Clock and data pins relocate by alternate select; reset default.
// - Sync bit set, clock source clear, port enable set: slave active.
// - Two writes: first transmits at once, second stays buffered.
// - A complete word moves from receive shift into receive data.
`include "sync_serial_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sync_slave_serial (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [5:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic sleep_i,
    output logic wake_o,
    output logic isr_call_o,
    output logic [11:0] isr_vector_o,
    output logic irq_o,
    input wire logic ck_a_i,
    input wire logic ck_b_i,
    input wire logic dt_a_i,
    output logic dt_a_o,
    output logic dt_a_oe_b_o,
    input wire logic dt_b_i,
    output logic dt_b_o,
    output logic dt_b_oe_b_o
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second
    logic [1:0] ck_s1, ck_s2, dt_s1, dt_s2;
    logic ck_prev, ck_sel;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ck_s1 <= 2'h0;
            ck_s2 <= 2'h0;
            dt_s1 <= 2'h0;
            dt_s2 <= 2'h0;
            ck_prev <= 1'b0;
        end else begin
            ck_s1 <= {ck_b_i, ck_a_i};
            ck_s2 <= ck_s1;
            dt_s1 <= {dt_b_i, dt_a_i};
            dt_s2 <= dt_s1;
            ck_prev <= ck_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] tx_ctrl, rx_ctrl, int_ctrl, irq_en, alt_pin;
    logic overrun, next_overrun;
    logic [7:0] next_tx_ctrl, next_rx_ctrl, next_int_ctrl;
    logic [7:0] next_irq_en, next_alt_pin;
    sync_serial_pkg::byte_t rx_mem [2];
    sync_serial_pkg::byte_t next_rx_mem [2];
    logic rx_wr, next_rx_wr, rx_rd, next_rx_rd;
    logic [1:0] rx_cnt, next_rx_cnt;
    sync_serial_pkg::byte_t rx_shift, next_rx_shift;
    logic [2:0] rx_bits, next_rx_bits;
    sync_serial_pkg::byte_t tx_buf, next_tx_buf, transmit_shift_register, next_tsr;
    logic tx_full, next_tx_full, tsr_busy, next_tsr_busy;
    logic [2:0] tx_bits, next_tx_bits;
    logic [2:0] ev_stat, next_ev_stat, ev_mask, next_ev_mask;
    logic ack, next_ack, wake, next_wake, isr, next_isr;
    logic [31:0] rdata, next_rdata;
    // Decoded controls
    logic dt_sel, ck_rise, ck_fall, slave_run, take;
    logic receive_complete_flag, transmit_buffer_empty_flag, tx_move, rx_push, rx_pop, tx_wr;
    sync_serial_pkg::port_mode_t mode;
    // Alternate select picks the pin pair; zero after reset is the default
    assign ck_sel = alt_pin[`SS_CK_ALT] ? ck_s2[1] : ck_s2[0];
    assign dt_sel = alt_pin[`SS_DT_ALT] ? dt_s2[1] : dt_s2[0];
    assign ck_rise = ck_sel & ~ck_prev;
    assign ck_fall = ~ck_sel & ck_prev;
    // Slave mode needs no system-derived clock, so it alone runs in sleep
    assign slave_run = rx_ctrl[`SS_PORT_EN] & tx_ctrl[`SS_SYNC]
        & ~tx_ctrl[`SS_CLK_SRC];
    always_comb begin
        if (!slave_run)
            mode = sync_serial_pkg::mode_off;
        else if (rx_ctrl[`SS_CONT_RX] | rx_ctrl[`SS_SINGLE_RX])
            mode = sync_serial_pkg::mode_receive;
        else if (tx_ctrl[`SS_TX_EN])
            mode = sync_serial_pkg::mode_transmit;
        else
            mode = sync_serial_pkg::mode_off;
    end
    // Flags are levels of the buffers
    assign receive_complete_flag = rx_cnt != 2'h0;
    assign transmit_buffer_empty_flag = ~tx_full;
    assign take = (read_i | write_i) & ack;
    assign rx_pop = take & read_i & (address_i == `SS_OFF_RX_DATA)
        & receive_complete_flag;
    assign tx_wr = take & write_i & byteenable_i[0]
        & (address_i == `SS_OFF_TX_BUF);
    assign tx_move = (mode == sync_serial_pkg::mode_transmit) & ~tsr_busy
        & tx_full;
    assign rx_push = (mode == sync_serial_pkg::mode_receive) & ck_rise
        & (rx_bits == `SS_LAST_BIT) & (rx_cnt != 2'h2);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for bus, shifters and flags
    always_comb begin
        next_tx_ctrl = tx_ctrl;
        next_rx_ctrl = rx_ctrl;
        next_int_ctrl = int_ctrl;
        next_irq_en = irq_en;
        next_alt_pin = alt_pin;
        next_overrun = overrun;
        next_rx_mem = rx_mem;
        next_rx_wr = rx_wr;
        next_rx_rd = rx_rd;
        next_rx_cnt = rx_cnt;
        next_rx_shift = rx_shift;
        next_rx_bits = rx_bits;
        next_tx_buf = tx_buf;
        next_tx_full = tx_full;
        next_tsr = transmit_shift_register;
        next_tsr_busy = tsr_busy;
        next_tx_bits = tx_bits;
        next_ev_mask = ev_mask;
        next_ev_stat = ev_stat;
        next_rdata = rdata;
        // One wait cycle, then the access completes
        next_ack = (read_i | write_i) & ~ack;
        if ((read_i | write_i) & ~ack) begin
            next_rdata = 32'h0000_0000;
            unique case (address_i)
                `SS_OFF_TX_CTRL: next_rdata[7:0] = {tx_ctrl[7:2],
                    ~tsr_busy, tx_ctrl[0]};
                `SS_OFF_RX_CTRL: next_rdata[7:0] = {rx_ctrl[7:2],
                    overrun, rx_ctrl[0]};
                `SS_OFF_RX_DATA: next_rdata[7:0] = rx_mem[rx_rd];
                `SS_OFF_FLAGS: begin
                    next_rdata[`SS_RX_FLAG] = receive_complete_flag;
                    next_rdata[`SS_TX_FLAG] = transmit_buffer_empty_flag;
                end
                `SS_OFF_EV_STAT: next_rdata[2:0] = ev_stat;
                `SS_OFF_EV_MASK: next_rdata[2:0] = ev_mask;
                `SS_OFF_INT_CTRL: next_rdata[7:0] = int_ctrl;
                `SS_OFF_IRQ_EN: next_rdata[7:0] = irq_en;
                `SS_OFF_ALT_PIN: next_rdata[7:0] = alt_pin;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        // Register writes; status bits are read-only positions
        if (take & write_i & byteenable_i[0]) begin
            unique case (address_i)
                `SS_OFF_TX_CTRL: next_tx_ctrl = writedata_i[7:0];
                `SS_OFF_RX_CTRL: next_rx_ctrl = writedata_i[7:0];
                `SS_OFF_EV_MASK: next_ev_mask = writedata_i[2:0];
                `SS_OFF_INT_CTRL: next_int_ctrl = writedata_i[7:0];
                `SS_OFF_IRQ_EN: next_irq_en = writedata_i[7:0];
                `SS_OFF_ALT_PIN: next_alt_pin = writedata_i[7:0];
                default: next_tx_ctrl = tx_ctrl;
            endcase
        end
        // Overrun clears when continuous receive or the port is disabled
        if (~next_rx_ctrl[`SS_CONT_RX] | ~next_rx_ctrl[`SS_PORT_EN])
            next_overrun = 1'b0;

        // Receive shifter samples the data pin on clock rising edges
        if (mode != sync_serial_pkg::mode_receive) begin
            next_rx_bits = 3'h0;
        end else if (ck_rise) begin
            next_rx_shift = {dt_sel, rx_shift[7:1]};
            next_rx_bits = rx_bits + 3'h1;
            if (rx_bits == `SS_LAST_BIT && rx_cnt == 2'h2)
                next_overrun = 1'b1;
        end
        // Receive buffer holds two words
        if (rx_push) begin
            next_rx_mem[rx_wr] = {dt_sel, rx_shift[7:1]};
            next_rx_wr = ~rx_wr;
        end
        if (rx_pop)
            next_rx_rd = ~rx_rd;
        next_rx_cnt = rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};

        // Transmit: a new bit goes out after each falling clock edge
        if (tsr_busy & ~slave_run) begin
            next_tsr_busy = 1'b0;
        end else if (tsr_busy & ck_fall) begin
            next_tsr = {1'b0, transmit_shift_register[7:1]};
            next_tx_bits = tx_bits + 3'h1;
            if (tx_bits == `SS_LAST_BIT)
                next_tsr_busy = 1'b0;
        end
        if (tx_move) begin
            next_tsr = tx_buf;
            next_tsr_busy = 1'b1;
            next_tx_bits = 3'h0;
            next_tx_full = 1'b0;
        end
        // A write is taken whenever the buffer is free
        if (tx_wr & ~tx_full) begin
            next_tx_buf = writedata_i[7:0];
            next_tx_full = 1'b1;
        end

        // Sticky events: a set in the clear cycle survives
        if (take & write_i & byteenable_i[0]
            & (address_i == `SS_OFF_EV_STAT))
            next_ev_stat = ev_stat & ~writedata_i[2:0];
        next_ev_stat[`SS_EV_RX] = next_ev_stat[`SS_EV_RX] | rx_push;
        next_ev_stat[`SS_EV_TX] = next_ev_stat[`SS_EV_TX] | tx_move;
        next_ev_stat[`SS_EV_OVR] = next_ev_stat[`SS_EV_OVR]
            | (~overrun & next_overrun);
        // Wake while asleep; transmit needs both enables
        next_wake = sleep_i & ((receive_complete_flag & irq_en[`SS_RX_FLAG])
            | (transmit_buffer_empty_flag & irq_en[`SS_TX_FLAG]
            & int_ctrl[`SS_PERIPH_EN]));
        next_isr = next_wake & int_ctrl[`SS_GLOBAL_EN];
    end
    // Registering of all state except the pin synchronisers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            tx_ctrl <= `SS_RST_BYTE;
            rx_ctrl <= `SS_RST_BYTE;
            int_ctrl <= `SS_RST_BYTE;
            irq_en <= `SS_RST_BYTE;
            alt_pin <= `SS_RST_BYTE;
            overrun <= 1'b0;
            rx_mem[0] <= `SS_RST_BYTE;
            rx_mem[1] <= `SS_RST_BYTE;
            rx_wr <= 1'b0;
            rx_rd <= 1'b0;
            rx_cnt <= 2'h0;
            rx_shift <= `SS_RST_BYTE;
            rx_bits <= 3'h0;
            tx_buf <= `SS_RST_BYTE;
            tx_full <= 1'b0;
            transmit_shift_register <= `SS_RST_BYTE;
            tsr_busy <= 1'b0;
            tx_bits <= 3'h0;
            ev_stat <= `SS_RST_EV;
            ev_mask <= `SS_RST_EV;
            ack <= 1'b0;
            wake <= 1'b0;
            isr <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            tx_ctrl <= next_tx_ctrl;
            rx_ctrl <= next_rx_ctrl;
            int_ctrl <= next_int_ctrl;
            irq_en <= next_irq_en;
            alt_pin <= next_alt_pin;
            overrun <= next_overrun;
            rx_mem <= next_rx_mem;
            rx_wr <= next_rx_wr;
            rx_rd <= next_rx_rd;
            rx_cnt <= next_rx_cnt;
            rx_shift <= next_rx_shift;
            rx_bits <= next_rx_bits;
            tx_buf <= next_tx_buf;
            tx_full <= next_tx_full;
            transmit_shift_register <= next_tsr;
            tsr_busy <= next_tsr_busy;
            tx_bits <= next_tx_bits;
            ev_stat <= next_ev_stat;
            ev_mask <= next_ev_mask;
            ack <= next_ack;
            wake <= next_wake;
            isr <= next_isr;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; the data pin is driven only while a word is shifting
    assign readdata_o = rdata;
    assign waitrequest_o = (read_i | write_i) & ~ack;
    assign wake_o = wake;
    assign isr_call_o = isr;
    assign isr_vector_o = `SS_ISR_VECTOR;
    assign irq_o = |(ev_stat & ev_mask);
    assign dt_a_o = transmit_shift_register[0];
    assign dt_b_o = transmit_shift_register[0];
    assign dt_a_oe_b_o = ~(tsr_busy & ~alt_pin[`SS_DT_ALT]);
    assign dt_b_oe_b_o = ~(tsr_busy & alt_pin[`SS_DT_ALT]);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    stop_shift_a: assert property (
        !slave_run |=> $stable(rx_shift))
        else $error("receive shifter moved outside slave mode");
    ext_clock_a: assert property (
        tsr_busy && !ck_fall && !tx_move |=> $stable(transmit_shift_register))
        else $error("transmit shifter moved without clock edge");
    rx_pop_a: assert property (
        rx_pop && rx_cnt == 2'h1 && !rx_push |=> !receive_complete_flag)
        else $error("receive flag stayed set after last read");
    rx_wake_a: assert property (
        sleep_i && receive_complete_flag && irq_en[`SS_RX_FLAG] |=> wake_o)
        else $error("no wake on received word");
    isr_call_a: assert property (
        isr_call_o |-> wake_o && $past(int_ctrl[`SS_GLOBAL_EN]))
        else $error("interrupt call without wake and global enable");
    tx_write_a: assert property (tx_wr && !tx_full |=> !transmit_buffer_empty_flag)
        else $error("buffer empty flag not cleared by write");
    tx_move_a: assert property (
        tx_move |=> tsr_busy && ev_stat[`SS_EV_TX] && transmit_shift_register == $past(tx_buf))
        else $error("buffered byte did not move");
    tx_wake_a: assert property (
        !(receive_complete_flag && irq_en[`SS_RX_FLAG]) && !(irq_en[`SS_TX_FLAG]
        && int_ctrl[`SS_PERIPH_EN]) |=> !wake_o)
        else $error("transmit wake without both enables");
    pin_alt_a: assert property (
        !dt_b_oe_b_o |-> alt_pin[`SS_DT_ALT] && dt_a_oe_b_o)
        else $error("data pin driven at wrong location");
    rx_done_a: assert property (
        rx_push |=> receive_complete_flag && ev_stat[`SS_EV_RX])
        else $error("complete word not moved to receive data");
    rx_word_c: cover property (rx_push);
    tx_move_c: cover property (tx_move ##[1:200] tx_wr);
    wake_c: cover property (sleep_i ##1 isr_call_o);
endmodule
`default_nettype wire

// file: tb_sync_slave_serial.sv
// Purpose: Self-checking bench for the sleep-capable serial slave
// Assumes: Offsets from the map header; master model on the link pins
// Notes: Link bits take 125 ns unless the frame is stretched, unrelated in phase to the 10 ns clock
`include "sync_serial_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_sync_slave_serial;
    logic mclk_i, rst_b_i, read_i, write_i, sleep_i;
    logic [5:0] address_i;
    logic [3:0] byteenable_i;
    logic [31:0] writedata_i, readdata_o;
    logic waitrequest_o, wake_o, isr_call_o, irq_o;
    logic [11:0] isr_vector_o;
    logic ck_a_i, ck_b_i, dt_a_i, dt_b_i;
    logic dt_a_o, dt_a_oe_b_o, dt_b_o, dt_b_oe_b_o;
    logic m_ck, m_dt, dt_wire, alt_ck, alt_dt;
    logic [7:0] got;
    int err_total, n_tests;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    // Pins follow the alternate select last written; device drive wins
    assign ck_a_i = alt_ck ? 1'h0 : m_ck;
    assign ck_b_i = alt_ck ? m_ck : 1'h0;
    assign dt_wire = alt_dt ? (dt_b_oe_b_o ? m_dt : dt_b_o)
                            : (dt_a_oe_b_o ? m_dt : dt_a_o);
    assign dt_a_i = alt_dt ? 1'h0 : dt_wire;
    assign dt_b_i = alt_dt ? dt_wire : 1'h0;
    sync_slave_serial u_sync_slave_serial (.mclk_i(mclk_i),
        .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .byteenable_i(byteenable_i),
        .writedata_i(writedata_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .sleep_i(sleep_i), .wake_o(wake_o),
        .isr_call_o(isr_call_o), .isr_vector_o(isr_vector_o),
        .irq_o(irq_o), .ck_a_i(ck_a_i), .ck_b_i(ck_b_i), .dt_a_i(dt_a_i),
        .dt_a_o(dt_a_o), .dt_a_oe_b_o(dt_a_oe_b_o), .dt_b_i(dt_b_i),
        .dt_b_o(dt_b_o), .dt_b_oe_b_o(dt_b_oe_b_o));
    sync_master_model u_sync_master_model (.ck_o(m_ck), .dt_o(m_dt),
        .dt_i(dt_wire));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the whole run needs under two thousand cycles
    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Bus cycle: request held until waitrequest is seen low at an edge
    task automatic xfer(input logic rd, input logic [5:0] a,
                        input logic [7:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        address_i <= a;
        writedata_i <= {24'h000000, d};
        read_i <= rd;
        write_i <= ~rd;
        do @(posedge mclk_i); while (waitrequest_o !== 1'h0);
        q = readdata_o; // Read data stands at the edge that ends the wait
        read_i <= 1'h0;
        write_i <= 1'h0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'h0, a, d, q);
    endtask
    // Upper bits always expected zero, low byte under a mask
    task automatic rdchk(input string nm, input logic [5:0] a,
                         input logic [7:0] m, input logic [7:0] e);
        logic [31:0] q;
        xfer(1'h1, a, 8'h00, q);
        chk(nm, {24'h000000, e}, q & {24'hFFFFFF, m});
    endtask
    task automatic poll(input logic [5:0] a, input logic [7:0] m);
        logic [31:0] q;
        for (int k = 0; k < 10; k++) begin
            xfer(1'h1, a, 8'h00, q);
            if ((q[7:0] & m) !== 8'h00) break;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rdchk("alt_pin", `SS_OFF_ALT_PIN, 8'hFF, 8'h00);
        rdchk("ev_stat", `SS_OFF_EV_STAT, 8'hFF, 8'h00);
        rdchk("unmapped", 6'h3C, 8'hFF, 8'h00);
        chk("vector", 32'h00000004, {20'h00000, isr_vector_o});
        chk("irq", 32'h0, {31'h0, irq_o});
        $display("test reset done");
    endtask
    // Wrong mode must not shift even with clocks arriving in sleep
    task automatic t_no_slave();
        wr(`SS_OFF_RX_CTRL, 8'h90);
        sleep_i <= 1'h1;
        for (int c = 0; c < 2; c++) begin
            wr(`SS_OFF_TX_CTRL, c == 0 ? 8'h90 : 8'h00);
            u_sync_master_model.frame(8'hA5, 0, got);
            rdchk("no_rx", `SS_OFF_FLAGS, 8'h20, 8'h00);
        end
        $display("test wrong mode done");
    endtask
    task automatic t_rx();
        wr(`SS_OFF_TX_CTRL, 8'h10);
        wr(`SS_OFF_IRQ_EN, 8'h20);
        wr(`SS_OFF_INT_CTRL, 8'h80);
        u_sync_master_model.frame(8'hA5, 0, got);
        u_sync_master_model.frame(8'h5A, 40, got);
        // Third word finds both slots full: dropped, overrun raised
        u_sync_master_model.frame(8'hFF, 0, got);
        for (int k = 0; k < 20 && isr_call_o !== 1'h1; k++) @(negedge mclk_i);
        chk("wake", 32'h1, {31'h0, wake_o});
        chk("isr_call", 32'h1, {31'h0, isr_call_o});
        rdchk("overrun", `SS_OFF_RX_CTRL, 8'hFF, 8'h92);
        rdchk("rx_data0", `SS_OFF_RX_DATA, 8'hFF, 8'hA5);
        rdchk("rx_flag1", `SS_OFF_FLAGS, 8'h20, 8'h20);
        rdchk("rx_data1", `SS_OFF_RX_DATA, 8'hFF, 8'h5A);
        rdchk("rx_flag2", `SS_OFF_FLAGS, 8'h20, 8'h00);
        rdchk("ev_rx", `SS_OFF_EV_STAT, 8'h07, 8'h05);
        @(negedge mclk_i);
        chk("wake_off", 32'h0, {31'h0, wake_o});
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        wr(`SS_OFF_EV_MASK, 8'h01);
        @(negedge mclk_i);
        chk("irq_on", 32'h1, {31'h0, irq_o});
        wr(`SS_OFF_EV_STAT, 8'h01);
        @(negedge mclk_i);
        chk("irq_clr", 32'h0, {31'h0, irq_o});
        $display("test receive in sleep done");
    endtask
    // Two words written while still asleep; wake needs the peripheral enable too
    task automatic t_tx();
        wr(`SS_OFF_RX_CTRL, 8'h80);
        wr(`SS_OFF_TX_CTRL, 8'h30);
        wr(`SS_OFF_IRQ_EN, 8'h10);
        wr(`SS_OFF_INT_CTRL, 8'h00);
        wr(`SS_OFF_TX_BUF, 8'h3C);
        wr(`SS_OFF_TX_BUF, 8'hC3);
        rdchk("tx_full", `SS_OFF_FLAGS, 8'h10, 8'h00);
        rdchk("tx_busy", `SS_OFF_TX_CTRL, 8'hFF, 8'h30);
        @(negedge mclk_i);
        chk("dt_drive", 32'h0, {31'h0, dt_a_oe_b_o});
        u_sync_master_model.frame(8'h00, 0, got);
        chk("tx_word0", 32'h3C, {24'h000000, got});
        poll(`SS_OFF_FLAGS, 8'h10);
        rdchk("tx_empty", `SS_OFF_FLAGS, 8'h10, 8'h10);
        @(negedge mclk_i);
        chk("no_wake", 32'h0, {31'h0, wake_o});
        wr(`SS_OFF_INT_CTRL, 8'h40);
        for (int k = 0; k < 20 && wake_o !== 1'h1; k++) @(negedge mclk_i);
        chk("tx_wake", 32'h1, {31'h0, wake_o});
        chk("no_isr", 32'h0, {31'h0, isr_call_o});
        wr(`SS_OFF_TX_BUF, 8'h55);
        rdchk("tx_refill", `SS_OFF_FLAGS, 8'h10, 8'h00);
        u_sync_master_model.frame(8'h00, 30, got);
        chk("tx_word1", 32'hC3, {24'h000000, got});
        u_sync_master_model.frame(8'h00, 0, got);
        chk("tx_word2", 32'h55, {24'h000000, got});
        rdchk("ev_tx", `SS_OFF_EV_STAT, 8'h02, 8'h02);
        @(negedge mclk_i);
        chk("dt_release", 32'h1, {31'h0, dt_a_oe_b_o});
        rdchk("tx_idle", `SS_OFF_TX_CTRL, 8'hFF, 8'h32);
        $display("test transmit in sleep done");
    endtask
    task automatic t_alt();
        wr(`SS_OFF_ALT_PIN, 8'h06);
        wr(`SS_OFF_RX_CTRL, 8'hA0); // Single receive selects receive too
        alt_ck = 1'h1;
        alt_dt = 1'h1;
        u_sync_master_model.frame(8'h96, 0, got);
        poll(`SS_OFF_FLAGS, 8'h20);
        rdchk("alt_rx", `SS_OFF_RX_DATA, 8'hFF, 8'h96);
        rdchk("alt_rb", `SS_OFF_ALT_PIN, 8'hFF, 8'h06);
        // Transmit on the moved data pin; the default pin must stay free
        wr(`SS_OFF_RX_CTRL, 8'h80);
        wr(`SS_OFF_TX_BUF, 8'hA9);
        repeat (2) @(negedge mclk_i);
        chk("alt_oe_a", 32'h1, {31'h0, dt_a_oe_b_o});
        chk("alt_oe_b", 32'h0, {31'h0, dt_b_oe_b_o});
        u_sync_master_model.frame(8'h00, 0, got);
        chk("alt_tx", 32'hA9, {24'h000000, got});
        $display("test alternate pins done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_b_i = 1'h0;
        read_i = 1'h0;
        write_i = 1'h0;
        sleep_i = 1'h0;
        address_i = 6'h00;
        byteenable_i = 4'h1;
        writedata_i = 32'h00000000;
        alt_ck = 1'h0;
        alt_dt = 1'h0;
        err_total = 0;
        n_tests = 0;
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'h1;
        t_reset();
        t_no_slave();
        t_rx();
        t_tx();
        t_alt();
        end_sim();
    end
endmodule
`default_nettype wire
